/* File: verilog/rx_pkg.sv */
// shared constants of the receive control block
package rx_pkg;

	typedef enum logic [2:0] {
		MODE_SLEEP   = 3'b000,
		MODE_STANDBY = 3'b001,
		MODE_SYNTH   = 3'b010,
		MODE_RX      = 3'b100,
		MODE_LISTEN  = 3'b111
	} mode_e;

	typedef enum logic [1:0] {
		ENG_IDLE   = 2'b00,
		ENG_MEAS   = 2'b01,
		ENG_RELOCK = 2'b10
	} engine_e;

	// register addresses
	localparam logic [7:0] A_OPMODE    = 8'h01;
	localparam logic [7:0] A_BR_HI     = 8'h02;
	localparam logic [7:0] A_BR_LO     = 8'h03;
	localparam logic [7:0] A_CORR_CTRL = 8'h04;
	localparam logic [7:0] A_DATA_CFG  = 8'h05;
	localparam logic [7:0] A_FEI_HI    = 8'h06;
	localparam logic [7:0] A_FEI_LO    = 8'h07;
	localparam logic [7:0] A_CORR_HI   = 8'h08;
	localparam logic [7:0] A_CORR_LO   = 8'h09;
	localparam logic [7:0] A_CARR_HI   = 8'h0a;
	localparam logic [7:0] A_CARR_LO   = 8'h0b;
	localparam logic [7:0] A_CORR_BW   = 8'h0c;
	localparam logic [7:0] A_RX_BW     = 8'h0d;
	localparam logic [7:0] A_TO_START  = 8'h0e;
	localparam logic [7:0] A_TO_THR    = 8'h0f;
	localparam logic [7:0] A_TEMP      = 8'h10;
	localparam logic [7:0] A_STATUS    = 8'h11;

	// field positions
	localparam int OM_SEQ_OFF  = 7;
	localparam int OM_LISTEN   = 6;
	localparam int OM_MODE_LSB = 2;
	localparam int CC_AUTO     = 0;
	localparam int CC_CLEAR    = 1;
	localparam int CC_AFC_GO   = 2;
	localparam int CC_FEI_GO   = 3;
	localparam int CC_FEI_DONE = 4;
	localparam int CC_AFC_DONE = 5;
	localparam int DC_PACKET   = 0;
	localparam int DC_SYNC_OFF = 1;
	localparam int DC_FAST     = 2;
	localparam int DC_TEMP_GO  = 3;
	localparam int ST_STATE    = 0;
	localparam int ST_ENG      = 3;
	localparam int ST_TEMP     = 4;
	localparam int ST_PLL      = 5;
	localparam int ST_READY    = 6;
	localparam int ST_TIMEOUT  = 7;
	localparam int SY_DATA     = 0;
	localparam int SY_PLL      = 1;
	localparam int SY_OSC      = 2;
	localparam int SY_RSSI     = 3;

	// reset values, write mask and temperature reference
	localparam logic [7:0]  OPMODE_RST  = 8'h04;
	localparam logic [7:0]  OPMODE_MASK = 8'hdc;
	localparam logic [15:0] BR_RST      = 16'h1a0b;
	localparam logic [15:0] CARR_RST    = 16'h8000;
	localparam logic [7:0]  BW_RST      = 8'h55;
	localparam logic [7:0]  TO_RST      = 8'h00;
	localparam logic [7:0]  TEMP_REF    = 8'hc8;

	// timing
	localparam int CLK_NS        = 40;
	localparam int PLL_BW_KHZ    = 300;
	localparam int RELOCK_PERIOD = 5;
	localparam int RELOCK_CYC    = (RELOCK_PERIOD * 1000000
		+ PLL_BW_KHZ * CLK_NS - 1) / (PLL_BW_KHZ * CLK_NS);
	localparam logic [8:0] RELOCK_MAX = 9'(RELOCK_CYC - 1);
	localparam int TEMP_CONV_US  = 100;
	localparam int TEMP_CYC      = TEMP_CONV_US * 1000 / CLK_NS;
	localparam logic [11:0] TEMP_MAX  = 12'(TEMP_CYC - 1);
	localparam logic [2:0] FEI_LAST   = 3'd3;
	localparam logic [2:0] PRE_LAST   = 3'd7;
	localparam logic [2:0] SETTLE_FULL = 3'd4;
	localparam logic [2:0] FAST_SAVE   = 3'd2;
	localparam logic [2:0] SETTLE_FAST = SETTLE_FULL - FAST_SAVE;

endpackage

/* File: verilog/bit_sync.sv */
// bit synchronizer: recovers bit clock and data
`timescale 1ns/10ps
`default_nettype none
module bit_sync (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        enable,
	input  wire logic        resync,
	input  wire logic [15:0] period,
	input  wire logic        data_in,
	output logic             bit_clock,
	output logic             bit_data,
	output logic             bit_strobe
);
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic [15:0] half;
	logic        last;
	logic        next_clock;
	logic        next_data;
	logic        next_strobe;

	always_comb begin
		half = period >> 1;
		next_cnt = cnt + 16'd1;
		next_data = bit_data;
		next_strobe = 1'b0;
		if (!enable)
			next_cnt = '0;
		else if (resync && data_in != last)
			next_cnt = '0;
		else if (cnt >= period - 16'd1)
			next_cnt = '0;
		if (enable && cnt == half) begin
			next_strobe = 1'b1;
			next_data = data_in;
		end
		next_clock = enable && cnt > half;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= '0;
			last <= 1'b0;
			bit_clock <= 1'b0;
			bit_data <= 1'b0;
			bit_strobe <= 1'b0;
		end else begin
			cnt <= next_cnt;
			last <= data_in;
			bit_clock <= next_clock;
			bit_data <= next_data;
			bit_strobe <= next_strobe;
		end
	end

endmodule
`default_nettype wire

/* File: verilog/rx_control.sv */
// receive control: modes, bit sync, afc, temperature, timeouts
`timescale 1ns/10ps
`default_nettype none
module rx_control
	import rx_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [7:0]  reg_rdata,
	input  wire logic        demod_data,
	input  wire logic        pll_lock_raw,
	input  wire logic        osc_ready_raw,
	input  wire logic        rssi_above_raw,
	input  wire logic [15:0] freq_offset,
	input  wire logic [7:0]  temp_adc,
	output logic             recovered_clock_pin,
	output logic             recovered_data,
	output logic             pll_lock_pin,
	output logic             receiver_ready_event,
	output logic             timeout_irq,
	output logic             osc_enable,
	output logic             synth_enable,
	output logic             receiver_enable,
	output logic             listen_active,
	output logic             temp_active,
	output logic      [7:0]  filter_bw,
	output logic      [15:0] carrier_freq
);
	logic [3:0]  sync1;
	logic [3:0]  sync2;
	logic        rssi_q;
	mode_e       state;
	mode_e       next_state;
	mode_e       prev_state;
	mode_e       target;
	logic        up;
	logic        lowish;
	logic [2:0]  mode_f;
	logic        rx_entry;
	logic        sync_on;
	logic        bs_clock;
	logic        bs_data;
	logic        tick;
	logic [7:0]  op_mode, next_op_mode;
	logic [15:0] br, next_br;
	logic        cc_auto, next_cc_auto;
	logic        cc_clear, next_cc_clear;
	logic [2:0]  dcfg, next_dcfg;
	logic [15:0] fei_res, next_fei_res;
	logic [15:0] corr, next_corr;
	logic [15:0] carr, next_carr;
	logic [7:0]  corr_bw, next_corr_bw;
	logic [7:0]  rx_bw, next_rx_bw;
	logic [7:0]  to_start, next_to_start;
	logic [7:0]  to_thr, next_to_thr;
	logic [7:0]  temp_read, next_temp_read;
	logic        fei_done, next_fei_done;
	logic        afc_done, next_afc_done;
	engine_e     eng, next_eng;
	logic        is_afc, next_is_afc;
	logic [2:0]  meas, next_meas;
	logic [8:0]  relock, next_relock;
	logic        temp_busy, next_temp_busy;
	logic [11:0] temp_cnt, next_temp_cnt;
	logic [2:0]  pre, next_pre;
	logic [7:0]  tcount, next_tcount;
	logic        thr_seen, next_thr_seen;
	logic        timeout, next_timeout;
	logic [2:0]  settle, next_settle;
	logic        rx_ready, next_rx_ready;
	logic [2:0]  settle_need;
	logic [7:0]  limit;
	logic [7:0]  rd;
	logic        fei_go;
	logic        afc_go;
	logic        afc_start;
	logic        temp_go;
	logic        thr_rise;

	////////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {rssi_above_raw, osc_ready_raw, pll_lock_raw,
				demod_data};
			sync2 <= sync1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// mode sequencer
	assign mode_f = op_mode[OM_MODE_LSB +: 3];
	assign lowish = state == MODE_SLEEP || state == MODE_LISTEN;

	always_comb begin
		if (op_mode[OM_LISTEN])
			target = MODE_LISTEN;
		else if (mode_f inside {MODE_SLEEP, MODE_STANDBY, MODE_SYNTH,
			MODE_RX})
			target = mode_e'(mode_f);
		else
			target = state;
		up = (target == MODE_RX && state != MODE_RX)
			|| (target == MODE_SYNTH && (lowish || state == MODE_STANDBY))
			|| (target == MODE_STANDBY && lowish);
		next_state = target;
		if (!op_mode[OM_SEQ_OFF] && up) begin
			unique case (state)
				MODE_SLEEP, MODE_LISTEN: next_state = MODE_STANDBY;
				MODE_STANDBY: begin
					if (sync2[SY_OSC])
						next_state = MODE_SYNTH;
					else
						next_state = MODE_STANDBY;
				end
				MODE_SYNTH: begin
					if (sync2[SY_PLL])
						next_state = MODE_RX;
					else
						next_state = MODE_SYNTH;
				end
				default: next_state = target;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state <= MODE_SLEEP;
			prev_state <= MODE_SLEEP;
		end else begin
			state <= next_state;
			prev_state <= state;
		end
	end

	assign rx_entry = state == MODE_RX && prev_state != MODE_RX;
	assign osc_enable = !lowish;
	assign synth_enable = state == MODE_SYNTH || state == MODE_RX;
	assign receiver_enable = state == MODE_RX;
	assign listen_active = state == MODE_LISTEN;
	assign pll_lock_pin = sync2[SY_PLL];

	////////////////////////////////////////////////////////////////////
	// bit synchroniser and bit-period tick
	// forced in packet mode
	assign sync_on = dcfg[DC_PACKET] || !dcfg[DC_SYNC_OFF];

	bit_sync u_data (
		.clock      (clock),
		.rst_b      (rst_b),
		.enable     (sync_on && state == MODE_RX),
		.resync     (1'b1),
		.period     (br),
		.data_in    (sync2[SY_DATA]),
		.bit_clock  (bs_clock),
		.bit_data   (bs_data),
		.bit_strobe ()
	);

	bit_sync u_tick (
		.clock      (clock),
		.rst_b      (rst_b),
		.enable     (state == MODE_RX),
		.resync     (1'b0),
		.period     (br),
		.data_in    (1'b0),
		.bit_clock  (),
		.bit_data   (),
		.bit_strobe (tick)
	);

	////////////////////////////////////////////////////////////////////
	// registers, correction engine, temperature, timeouts
	assign thr_rise = sync2[SY_RSSI] && !rssi_q;
	assign limit = thr_seen ? to_thr : to_start;
	assign settle_need = dcfg[DC_FAST] ? SETTLE_FAST : SETTLE_FULL;
	assign fei_go = reg_write && reg_addr == A_CORR_CTRL
		&& reg_wdata[CC_FEI_GO] && state == MODE_RX;
	assign afc_go = reg_write && reg_addr == A_CORR_CTRL
		&& reg_wdata[CC_AFC_GO] && !cc_auto && state == MODE_RX;
	assign afc_start = (rx_entry && cc_auto) || afc_go;
	assign temp_go = reg_write && reg_addr == A_DATA_CFG
		&& reg_wdata[DC_TEMP_GO];

	always_comb begin
		next_op_mode = op_mode;
		next_br = br;
		next_cc_auto = cc_auto;
		next_cc_clear = cc_clear;
		next_dcfg = dcfg;
		next_fei_res = fei_res;
		next_corr = corr;
		next_carr = carr;
		next_corr_bw = corr_bw;
		next_rx_bw = rx_bw;
		next_to_start = to_start;
		next_to_thr = to_thr;
		next_temp_read = temp_read;
		next_fei_done = fei_done;
		next_afc_done = afc_done;
		next_eng = eng;
		next_is_afc = is_afc;
		next_meas = meas;
		next_relock = relock;
		next_temp_busy = temp_busy;
		next_temp_cnt = temp_cnt;
		next_pre = pre;
		next_tcount = tcount;
		next_thr_seen = thr_seen;
		next_timeout = timeout;
		next_settle = settle;
		next_rx_ready = rx_ready;
		if (reg_write) begin
			case (reg_addr)
				A_OPMODE:    next_op_mode = reg_wdata & OPMODE_MASK;
				A_BR_HI:     next_br[15:8] = reg_wdata;
				A_BR_LO:     next_br[7:0] = reg_wdata;
				A_CORR_CTRL: begin
					next_cc_auto = reg_wdata[CC_AUTO];
					next_cc_clear = reg_wdata[CC_CLEAR];
				end
				A_DATA_CFG:  next_dcfg = reg_wdata[2:0];
				A_CARR_HI:   next_carr[15:8] = reg_wdata;
				A_CARR_LO:   next_carr[7:0] = reg_wdata;
				A_CORR_BW:   next_corr_bw = reg_wdata;
				A_RX_BW:     next_rx_bw = reg_wdata;
				A_TO_START:  next_to_start = reg_wdata;
				A_TO_THR:    next_to_thr = reg_wdata;
				default:     ;
			endcase
		end
		unique case (eng)
			ENG_IDLE: begin
				if (afc_start) begin
					next_eng = ENG_MEAS;
					next_is_afc = 1'b1;
					next_meas = '0;
					next_afc_done = 1'b0;
					next_fei_done = 1'b0;
					if (cc_auto && cc_clear) begin
						next_carr = carr + corr;
						next_corr = '0;
					end
				end else if (fei_go) begin
					next_eng = ENG_MEAS;
					next_is_afc = 1'b0;
					next_meas = '0;
					next_fei_done = 1'b0;
				end
			end
			ENG_MEAS: begin
				if (state != MODE_RX)
					next_eng = ENG_IDLE;
				else if (tick) begin
					if (meas == FEI_LAST) begin
						next_fei_res = freq_offset;
						next_fei_done = 1'b1;
						next_eng = ENG_IDLE;
						if (is_afc) begin
							next_carr = carr - freq_offset;
							next_corr = corr + freq_offset;
							next_afc_done = 1'b1;
							next_eng = ENG_RELOCK;
							next_relock = '0;
						end
					end else
						next_meas = meas + 3'd1;
				end
			end
			ENG_RELOCK: begin
				if (relock == RELOCK_MAX)
					next_eng = ENG_IDLE;
				else
					next_relock = relock + 9'd1;
			end
			default: next_eng = ENG_IDLE;
		endcase
		if (temp_busy) begin
			if (temp_cnt == TEMP_MAX) begin
				next_temp_busy = 1'b0;
				next_temp_read = TEMP_REF - temp_adc;
			end else
				next_temp_cnt = temp_cnt + 12'd1;
		end else if (temp_go && (state == MODE_STANDBY
			|| state == MODE_SYNTH)) begin
			next_temp_busy = 1'b1;
			next_temp_cnt = '0;
		end
		if (rx_entry) begin
			next_pre = '0;
			next_tcount = '0;
			next_thr_seen = 1'b0;
			next_timeout = 1'b0;
			next_settle = '0;
			next_rx_ready = 1'b0;
		end else if (state == MODE_RX) begin
			if (thr_rise && !thr_seen) begin
				next_thr_seen = 1'b1;
				next_pre = '0;
				next_tcount = '0;
			end else if (tick && !timeout) begin
				next_pre = pre + 3'd1;
				if (pre == PRE_LAST)
					next_tcount = tcount + 8'd1;
			end
			if (limit != TO_RST && tcount == limit)
				next_timeout = 1'b1;
			if (!rx_ready && eng == ENG_IDLE && settle >= settle_need)
				next_rx_ready = 1'b1;
			else if (tick && settle < settle_need)
				next_settle = settle + 3'd1;
		end
	end

	always_comb begin
		rd = '0;
		case (reg_addr)
			A_OPMODE:    rd = op_mode;
			A_BR_HI:     rd = br[15:8];
			A_BR_LO:     rd = br[7:0];
			A_CORR_CTRL: begin
				rd[CC_AUTO] = cc_auto;
				rd[CC_CLEAR] = cc_clear;
				rd[CC_FEI_DONE] = fei_done;
				rd[CC_AFC_DONE] = afc_done;
			end
			A_DATA_CFG:  rd[2:0] = dcfg;
			A_FEI_HI:    rd = fei_res[15:8];
			A_FEI_LO:    rd = fei_res[7:0];
			A_CORR_HI:   rd = corr[15:8];
			A_CORR_LO:   rd = corr[7:0];
			A_CARR_HI:   rd = carr[15:8];
			A_CARR_LO:   rd = carr[7:0];
			A_CORR_BW:   rd = corr_bw;
			A_RX_BW:     rd = rx_bw;
			A_TO_START:  rd = to_start;
			A_TO_THR:    rd = to_thr;
			A_TEMP:      rd = temp_read;
			A_STATUS:    begin
				rd[ST_STATE +: 3] = state;
				rd[ST_ENG] = eng != ENG_IDLE;
				rd[ST_TEMP] = temp_busy;
				rd[ST_PLL] = sync2[SY_PLL];
				rd[ST_READY] = rx_ready;
				rd[ST_TIMEOUT] = timeout;
			end
			default:     rd = '0;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			op_mode <= OPMODE_RST;
			br <= BR_RST;
			cc_auto <= 1'b0;
			cc_clear <= 1'b0;
			dcfg <= '0;
			fei_res <= '0;
			corr <= '0;
			carr <= CARR_RST;
			corr_bw <= BW_RST;
			rx_bw <= BW_RST;
			to_start <= TO_RST;
			to_thr <= TO_RST;
			temp_read <= '0;
			fei_done <= 1'b0;
			afc_done <= 1'b0;
			eng <= ENG_IDLE;
			is_afc <= 1'b0;
			meas <= '0;
			relock <= '0;
			temp_busy <= 1'b0;
			temp_cnt <= '0;
			pre <= '0;
			tcount <= '0;
			thr_seen <= 1'b0;
			timeout <= 1'b0;
			settle <= '0;
			rx_ready <= 1'b0;
			rssi_q <= 1'b0;
			reg_rdata <= '0;
			receiver_ready_event <= 1'b0;
			recovered_clock_pin <= 1'b0;
			recovered_data <= 1'b0;
			filter_bw <= BW_RST;
		end else begin
			op_mode <= next_op_mode;
			br <= next_br;
			cc_auto <= next_cc_auto;
			cc_clear <= next_cc_clear;
			dcfg <= next_dcfg;
			fei_res <= next_fei_res;
			corr <= next_corr;
			carr <= next_carr;
			corr_bw <= next_corr_bw;
			rx_bw <= next_rx_bw;
			to_start <= next_to_start;
			to_thr <= next_to_thr;
			temp_read <= next_temp_read;
			fei_done <= next_fei_done;
			afc_done <= next_afc_done;
			eng <= next_eng;
			is_afc <= next_is_afc;
			meas <= next_meas;
			relock <= next_relock;
			temp_busy <= next_temp_busy;
			temp_cnt <= next_temp_cnt;
			pre <= next_pre;
			tcount <= next_tcount;
			thr_seen <= next_thr_seen;
			timeout <= next_timeout;
			settle <= next_settle;
			rx_ready <= next_rx_ready;
			rssi_q <= sync2[SY_RSSI];
			reg_rdata <= reg_read ? rd : 8'h00;
			receiver_ready_event <= next_rx_ready && !rx_ready;
			recovered_clock_pin <= sync_on ? bs_clock : 1'b0;
			recovered_data <= sync_on ? bs_data : sync2[SY_DATA];
			filter_bw <= (eng == ENG_MEAS && is_afc) ? corr_bw : rx_bw;
		end
	end

	assign timeout_irq = timeout;
	assign temp_active = temp_busy;
	assign carrier_freq = carr;

	////////////////////////////////////////////////////////////////////
	// assertions
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_fei_four_bits: assert property (
		$rose(fei_done) |-> $past(meas) == FEI_LAST)
		else $error("measurement ended early");
	a_carrier_minus: assert property (
		$rose(afc_done) |-> carr == $past(carr) - $past(freq_offset))
		else $error("carrier not corrected");
	a_relock_wait: assert property (
		eng == ENG_RELOCK ##1 eng == ENG_IDLE
		|-> $past(relock) == RELOCK_MAX)
		else $error("relock wait wrong");
	a_corr_bandwidth: assert property (
		eng == ENG_MEAS && is_afc |=> filter_bw == $past(corr_bw))
		else $error("wrong filter bandwidth");
	a_temp_mode_gate: assert property (
		$rose(temp_busy) |-> $past(state) inside {MODE_STANDBY,
		MODE_SYNTH})
		else $error("temperature in wrong mode");
	a_direct_entry: assert property (
		op_mode[OM_SEQ_OFF] && !op_mode[OM_LISTEN] && mode_f == MODE_RX
		|=> state == MODE_RX)
		else $error("direct entry failed");
	a_rx_after_lock: assert property (
		$rose(state == MODE_RX) && !$past(op_mode[OM_SEQ_OFF])
		|-> $past(state) == MODE_SYNTH && $past(sync2[SY_PLL]))
		else $error("rx entered without lock");
	a_listen_override: assert property (
		op_mode[OM_LISTEN] |=> state == MODE_LISTEN)
		else $error("listen not entered");
	a_start_timeout: assert property (
		$rose(timeout) && !$past(thr_seen)
		|-> $past(tcount) == $past(to_start))
		else $error("start timeout count wrong");
	a_thresh_timeout: assert property (
		$rose(timeout) && $past(thr_seen)
		|-> $past(tcount) == $past(to_thr))
		else $error("threshold timeout count wrong");

	c_afc_done: cover property ($rose(afc_done));
	c_timeout: cover property ($rose(timeout));
	c_temp_done: cover property ($fell(temp_busy));
	c_rx_ready: cover property ($rose(receiver_ready_event));

endmodule
`default_nettype wire

/* File: tb/rx_far_side.sv */
// far side model: oscillator, synthesizer and sender
`timescale 1ns/10ps
`default_nettype none
module rx_far_side (
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic osc_enable,
	input  wire logic synth_enable,
	input  wire logic receiver_enable,
	output logic      osc_ready_raw,
	output logic      pll_lock_raw,
	output logic      demod_data
);
	logic [3:0] osc_dly;
	logic [3:0] pll_dly;
	////////////////////////////////////////////////////////////////////
	// oscillator and synthesizer settle a few cycles after enable
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			osc_dly <= 4'h0;
			pll_dly <= 4'h0;
		end else begin
			osc_dly <= {osc_dly[2:0], osc_enable};
			pll_dly <= {pll_dly[2:0], synth_enable};
		end
	end
	assign osc_ready_raw = osc_dly[3];
	assign pll_lock_raw = pll_dly[3];
	////////////////////////////////////////////////////////////////////
	// alternating preamble bits
	initial begin
		demod_data = 1'b0;
		#7;
		forever #320 demod_data = receiver_enable ? ~demod_data : demod_data;
	end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// bench for the receive control block
`timescale 1ns/10ps
`default_nettype none
module tb;
	import rx_pkg::*;
	logic        clock, rst_b, reg_write, reg_read, rssi;
	logic [7:0]  reg_addr, reg_wdata, temp_adc, d;
	logic [2:0]  dly;
	logic [15:0] freq_offset;
	logic [31:0] seed;
	wire logic   dat, lock, osc_r, osc_e, syn_e, rx_e, lst, tmp, rdy, to;
	wire logic   rclk, rdat, lock_pin;
	logic [7:0]  rdata, bw;
	logic [15:0] carr;
	int          miscompares, check_count, n;
	int          cyc, rdy_at, hi_n, t0, h0, lat;
	localparam int BIT_CYC = 8;
	rx_control u_rx_control (.clock(clock), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(rdata), .demod_data(dat),
		.pll_lock_raw(lock), .osc_ready_raw(osc_r), .rssi_above_raw(rssi),
		.freq_offset(freq_offset), .temp_adc(temp_adc),
		.recovered_clock_pin(rclk), .recovered_data(rdat),
		.pll_lock_pin(lock_pin), .receiver_ready_event(rdy),
		.timeout_irq(to), .osc_enable(osc_e), .synth_enable(syn_e),
		.receiver_enable(rx_e), .listen_active(lst), .temp_active(tmp),
		.filter_bw(bw), .carrier_freq(carr));
	rx_far_side u_rx_far_side (.clock(clock), .rst_b(rst_b),
		.osc_enable(osc_e), .synth_enable(syn_e), .receiver_enable(rx_e),
		.osc_ready_raw(osc_r), .pll_lock_raw(lock), .demod_data(dat));
	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic poll(input logic [7:0] a, input int b);
		for (n = 0; n < 400; n++) begin
			rd(a);
			if (d[b] === 1'b1)
				break;
		end
		expire(400);
	endtask
	task automatic expire(input int lim);
		if (n == lim) begin
			miscompares++;
			end_of_test();
		end
	endtask
	task automatic wait_hi(input int lim);
		for (n = 0; n < lim && rx_e !== 1'b1; n++)
			@(posedge clock);
		expire(lim);
	endtask
	task automatic enter_rx(input logic [7:0] cfg);
		wr(A_DATA_CFG, cfg);
		wr(A_OPMODE, 8'h84);
		wr(A_OPMODE, 8'h90);
		t0 = cyc;
		h0 = hi_n;
		repeat (60) @(posedge clock);
	endtask
	// cycle count, ready pulse time, clock highs, raw data delay
	always @(posedge clock) begin
		cyc <= cyc + 1;
		dly <= {dly[1:0], dat};
		if (rdy === 1'b1)
			rdy_at <= cyc;
		if (rclk === 1'b1)
			hi_n <= hi_n + 1;
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	initial begin
		{rst_b, reg_write, reg_read, rssi} = 4'h0;
		{reg_addr, reg_wdata, temp_adc, freq_offset} = 32'h0;
		seed = 32'hf02a49b8;
		miscompares = 0;
		check_count = 0;
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		rd(A_OPMODE);
		chk(d, OPMODE_RST);
		rd(A_CARR_HI);
		chk(d, CARR_RST[15:8]);
		rd(8'h20);
		chk(d, 8'h00);
		wr(A_BR_HI, 8'h00);
		wr(A_BR_LO, 8'(BIT_CYC));
		$display("reset test done");
		for (int m = 0; m < 5; m++) begin
			if (m == 3)
				continue;
			wr(A_OPMODE, 8'h80 | 8'(m << 2));
			rd(A_STATUS);
			chk(d[2:0], m);
		end
		wr(A_OPMODE, 8'hc4);
		repeat (2) @(posedge clock);
		chk(lst, 1'b1);
		wr(A_OPMODE, 8'h00);
		wr(A_OPMODE, 8'h10);
		repeat (2) @(posedge clock);
		chk({syn_e, osc_e}, 2'b01);
		wait_hi(200);
		chk({lock_pin, syn_e}, 2'b11);
		$display("mode test done");
		for (n = 0; n < 100 && rclk !== 1'b1; n++)
			@(posedge clock);
		expire(100);
		chk(rclk, 1'b1);
		freq_offset <= 16'(rnd());
		wr(A_CORR_CTRL, 8'h01 << CC_FEI_GO);
		poll(A_CORR_CTRL, CC_FEI_DONE);
		rd(A_FEI_HI);
		chk(d, freq_offset[15:8]);
		rd(A_FEI_LO);
		chk(d, freq_offset[7:0]);
		wr(A_CORR_BW, 8'haa);
		wr(A_CORR_CTRL, 8'h01 << CC_AFC_GO);
		repeat (2) @(posedge clock);
		chk(bw, 8'haa);
		poll(A_CORR_CTRL, CC_AFC_DONE);
		chk(carr, CARR_RST - freq_offset);
		$display("correction test done");
		wr(A_DATA_CFG, 8'h01 << DC_TEMP_GO);
		repeat (2) @(posedge clock);
		chk(tmp, 1'b0);
		wr(A_OPMODE, 8'h84);
		temp_adc <= 8'(rnd());
		wr(A_DATA_CFG, 8'h01 << DC_TEMP_GO);
		repeat (2) @(posedge clock);
		chk(tmp, 1'b1);
		for (n = 0; n < 3000 && tmp !== 1'b0; n++)
			@(posedge clock);
		expire(3000);
		rd(A_TEMP);
		chk(d, 8'(TEMP_REF - temp_adc));
		$display("temperature test done");
		wr(A_TO_START, 8'h01);
		wr(A_OPMODE, 8'h90);
		repeat (40) @(posedge clock);
		chk(to, 1'b0);
		for (n = 0; n < 200 && to !== 1'b1; n++)
			@(posedge clock);
		expire(200);
		chk(to, 1'b1);
		$display("timeout test done");
		enter_rx(8'h01 << DC_SYNC_OFF);
		chk(hi_n - h0, 0);
		chk(rdat, dly[2]);
		lat = rdy_at - t0;
		// packet mode forces sync, fast settle
		enter_rx(8'h07);
		chk(hi_n - h0 > 0, 1'b1);
		chk(lat - (rdy_at - t0), FAST_SAVE * BIT_CYC);
		$display("settle test done");
		wr(A_TO_START, TO_RST);
		wr(A_TO_THR, 8'h02);
		enter_rx(8'h00);
		rssi <= 1'b1;
		repeat (100) @(posedge clock);
		chk(to, 1'b0);
		for (n = 0; n < 200 && to !== 1'b1; n++)
			@(posedge clock);
		expire(200);
		chk(to, 1'b1);
		rssi <= 1'b0;
		freq_offset <= 16'(rnd());
		wr(A_CORR_CTRL, 8'h03);
		enter_rx(8'h00);
		poll(A_CORR_CTRL, CC_AFC_DONE);
		chk(carr, CARR_RST - freq_offset);
		$display("threshold and auto test done");
		end_of_test();
	end
endmodule
`default_nettype wire
